// ### ohint_core.sv
// Behaviour
// - Driver setting the ownership change request sets the ownership-change flag, bit 30.
// - Unmasked ownership change raises the system management interrupt immediately, plus normal.
// - Without a system management interrupt pin the ownership-change flag reads zero.
// - Root hub or any port status change sets the root-hub-change flag, bit 6.
// - Frame number bit 15 toggling or shared frame number update sets bit 5.
// - A non-USB system error sets the unrecoverable-error flag, bit 4.
// - After an unrecoverable error all processing and bus signaling stop.
// - Rising resume signaling from a downstream device sets the resume flag, bit 3.
// - Resume entered by software command does not set the resume flag.
// - Start-of-frame flag, bit 2, is set with the SOF token each frame.
// - Writeback-done flag, bit 1, is set right after the done head copy.
// - While writeback-done is set, further done head copies are held off.
// - Frame overrun sets the scheduling-overrun flag, bit 0, after frame number write.
// - Each scheduling overrun increments the overrun counter field.
// - Host interrupt requested only when flag, its enable and master enable are all set; the management interrupt ignores master enable.
// - Enable register: writing 1 sets a bit, 0 leaves it; reads return value.
// - Writing 0 to master enable does nothing; 1 enables interrupt generation.
// - Enables sit at bit 30 and bits 6 to 0; bits 29 to 7 reserved.
`timescale 1ns/1ps
`default_nettype none

module ohint_core #(
    parameter bit SMI_PIN_PRESENT = 1'b1,
    parameter int SOC_WIDTH       = ohint_pkg::SOC_W,
    parameter int FRAME_WIDTH     = ohint_pkg::FRAME_W
) (
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    input  wire logic                   clock_enable,
    input  wire logic [7:0]             reg_addr,
    input  wire logic                   reg_write,
    input  wire logic                   reg_read,
    input  wire logic [31:0]            reg_wdata,
    output var  logic [31:0]            reg_rdata,
    input  wire logic                   ownership_change_request,
    input  wire logic                   root_hub_change,
    input  wire logic [FRAME_WIDTH-1:0] frame_number,
    input  wire logic                   shared_frame_number_written,
    input  wire logic                   system_error,
    input  wire logic                   bus_resume_signal,
    input  wire logic                   bus_resume_state,
    input  wire logic                   sof_token_issue,
    input  wire logic                   shared_done_queue_head_written,
    input  wire logic                   schedule_overrun,
    output var  logic                   host_irq,
    output var  logic                   system_mgmt_irq_pin,
    output var  logic                   processing_halt,
    output var  logic                   done_queue_head_hold,
    output var  logic [SOC_WIDTH-1:0]   sched_overrun_count
);

    localparam logic SMI_ON = SMI_PIN_PRESENT;

    // Register port decode.
    wire  logic                   status_hit;
    wire  logic                   enable_hit;
    wire  logic                   status_write;
    wire  logic                   enable_write;
    wire  logic [7:0]             wdata_events;

    // Event detection.
    logic                         frame_msb_prev;
    logic                         resume_prev;
    logic                         overrun_pending;
    wire  logic                   frame_msb_toggle;
    wire  logic                   oc_set;
    wire  logic                   root_hub_change_flag_set;
    wire  logic                   fno_set;
    wire  logic                   ue_set;
    wire  logic                   rd_set;
    wire  logic                   sf_set;
    wire  logic                   wdh_set;
    wire  logic                   so_set;
    wire  logic                   next_overrun_pending;

    // Flags and enables.
    wire  logic [7:0]             flag_set;
    wire  logic [7:0]             flag_clear;
    wire  logic [7:0]             flags;
    wire  logic [7:0]             next_flags;
    logic [7:0]                   enables;
    logic                         master_interrupt_enable;
    wire  logic [7:0]             next_enables;
    wire  logic                   next_mie;
    wire  logic [7:0]             next_pending;
    wire  logic                   next_host_irq;
    wire  logic                   next_smi;

    // Read path.
    wire  logic [31:0]            status_word;
    wire  logic [31:0]            enable_word;
    wire  logic [31:0]            next_rdata;
    wire  logic [SOC_WIDTH-1:0]   next_soc;

    assign status_hit   = (reg_addr == ohint_pkg::OFS_STATUS);
    assign enable_hit   = (reg_addr == ohint_pkg::OFS_ENABLE);
    assign status_write = reg_write & status_hit;
    assign enable_write = reg_write & enable_hit;

    // The OC bit and the seven low event bits of a written word, packed.
    assign wdata_events = {reg_wdata[ohint_pkg::BIT_OC],
                           reg_wdata[ohint_pkg::BIT_ROOT_HUB_CHANGE_FLAG:ohint_pkg::BIT_SO]};

    // Only the changing edge of the frame counter MSB counts as an overflow.
    assign frame_msb_toggle = frame_number[ohint_pkg::FRAME_MSB] ^ frame_msb_prev;

    assign oc_set   = ownership_change_request & SMI_ON;
    assign root_hub_change_flag_set = root_hub_change;
    assign fno_set  = frame_msb_toggle | shared_frame_number_written;
    assign ue_set   = system_error;
    assign rd_set   = bus_resume_signal & ~resume_prev & ~bus_resume_state;
    assign sf_set   = sof_token_issue;
    assign wdh_set  = shared_done_queue_head_written;

    // An overrun waits for the frame number write of its frame before flagging.
    assign so_set = (overrun_pending | schedule_overrun) & shared_frame_number_written;
    assign next_overrun_pending = (overrun_pending | schedule_overrun)
                                  & ~shared_frame_number_written;

    assign flag_set[ohint_pkg::IDX_SO]   = so_set;
    assign flag_set[ohint_pkg::IDX_WDH]  = wdh_set;
    assign flag_set[ohint_pkg::IDX_SF]   = sf_set;
    assign flag_set[ohint_pkg::IDX_RD]   = rd_set;
    assign flag_set[ohint_pkg::IDX_UE]   = ue_set;
    assign flag_set[ohint_pkg::IDX_FNO]  = fno_set;
    assign flag_set[ohint_pkg::IDX_ROOT_HUB_CHANGE_FLAG] = root_hub_change_flag_set;
    assign flag_set[ohint_pkg::IDX_OC]   = oc_set;

    // Writing 1 to a status position clears it; 0 leaves it alone.
    assign flag_clear = status_write ? wdata_events : 8'h00;

    ohint_flags #(
        .WIDTH        (ohint_pkg::NUM_FLAGS)
    ) u_flags (
        .clock        (clock),
        .reset_n      (reset_n),
        .clock_enable (clock_enable),
        .set          (flag_set),
        .clear        (flag_clear),
        .flags        (flags),
        .next_flags   (next_flags)
    );

    // Enables are set-only here; only reset clears them.
    assign next_enables = enable_write ? (enables | wdata_events) : enables;
    assign next_mie     = master_interrupt_enable | (enable_write & reg_wdata[ohint_pkg::BIT_MIE]);

    assign next_pending  = next_flags & next_enables;
    assign next_host_irq = next_mie & (|next_pending);
    assign next_smi      = SMI_ON & next_pending[ohint_pkg::IDX_OC];

    assign status_word = {1'b0,
                          flags[ohint_pkg::IDX_OC] & SMI_ON,
                          23'h000000,
                          flags[ohint_pkg::IDX_ROOT_HUB_CHANGE_FLAG:ohint_pkg::IDX_SO]};
    assign enable_word = {master_interrupt_enable,
                          enables[ohint_pkg::IDX_OC],
                          23'h000000,
                          enables[ohint_pkg::IDX_ROOT_HUB_CHANGE_FLAG:ohint_pkg::IDX_SO]};

    // Unmapped reads return zero.
    assign next_rdata = !reg_read  ? reg_rdata   :
                        status_hit ? status_word :
                        enable_hit ? enable_word :
                        ohint_pkg::RDATA_RESET;

    assign next_soc = schedule_overrun ? SOC_WIDTH'(sched_overrun_count + 1'b1)
                                       : sched_overrun_count;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            frame_msb_prev  <= 1'b0;
            resume_prev     <= 1'b0;
            overrun_pending <= 1'b0;
        end else if (clock_enable) begin
            frame_msb_prev  <= frame_number[ohint_pkg::FRAME_MSB];
            resume_prev     <= bus_resume_signal;
            overrun_pending <= next_overrun_pending;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            enables <= ohint_pkg::ENABLES_RESET;
            master_interrupt_enable     <= ohint_pkg::MIE_RESET;
        end else if (clock_enable) begin
            enables <= next_enables;
            master_interrupt_enable     <= next_mie;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            host_irq             <= 1'b0;
            system_mgmt_irq_pin  <= 1'b0;
            processing_halt      <= 1'b0;
            done_queue_head_hold <= 1'b0;
        end else if (clock_enable) begin
            host_irq             <= next_host_irq;
            system_mgmt_irq_pin  <= next_smi;
            processing_halt      <= next_flags[ohint_pkg::IDX_UE];
            done_queue_head_hold <= next_flags[ohint_pkg::IDX_WDH];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata           <= ohint_pkg::RDATA_RESET;
            sched_overrun_count <= '0;
        end else if (clock_enable) begin
            reg_rdata           <= next_rdata;
            sched_overrun_count <= next_soc;
        end
    end

endmodule

`default_nettype wire

// ### ohint_pkg.sv
package ohint_pkg;

    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          NUM_FLAGS       = 8;

    // Register offsets on the controller register port.
    localparam logic [7:0]  OFS_STATUS      = 8'h0c;
    localparam logic [7:0]  OFS_ENABLE      = 8'h10;

    // Bit positions in the status and enable words.
    localparam int          BIT_SO          = 0;
    localparam int          BIT_WDH         = 1;
    localparam int          BIT_SF          = 2;
    localparam int          BIT_RD          = 3;
    localparam int          BIT_UE          = 4;
    localparam int          BIT_FNO         = 5;
    localparam int          BIT_ROOT_HUB_CHANGE_FLAG        = 6;
    localparam int          BIT_OC          = 30;
    localparam int          BIT_MIE         = 31;

    // Index of each event inside the packed eight-bit flag vector.
    localparam int          IDX_SO          = 0;
    localparam int          IDX_WDH         = 1;
    localparam int          IDX_SF          = 2;
    localparam int          IDX_RD          = 3;
    localparam int          IDX_UE          = 4;
    localparam int          IDX_FNO         = 5;
    localparam int          IDX_ROOT_HUB_CHANGE_FLAG        = 6;
    localparam int          IDX_OC          = 7;

    localparam int          FRAME_W         = 16;
    localparam int          FRAME_MSB       = 15;
    localparam int          SOC_W           = 2;

    localparam logic [7:0]  FLAGS_RESET     = 8'h00;
    localparam logic [7:0]  ENABLES_RESET   = 8'h00;
    localparam logic        MIE_RESET       = 1'b0;
    localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;
    localparam logic [1:0]  SOC_RESET       = 2'h0;

endpackage

// ### ohint_flags.sv
`timescale 1ns/1ps
`default_nettype none

module ohint_flags #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             clock_enable,
    input  wire logic [WIDTH-1:0] set,
    input  wire logic [WIDTH-1:0] clear,
    output var  logic [WIDTH-1:0] flags,
    output var  logic [WIDTH-1:0] next_flags
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            // A set arriving with a clear in the same cycle wins.
            assign next_flags[i] = set[i] | (flags[i] & ~clear[i]);

            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    flags[i] <= 1'b0;
                end else if (clock_enable) begin
                    flags[i] <= next_flags[i];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ### ohint_core_checker.sv
`timescale 1ns/1ps
`default_nettype none

module ohint_core_checker #(
    parameter int SOC_WIDTH = 2
) (
    input wire logic                 clock,
    input wire logic                 reset_n,
    input wire logic                 clock_enable,
    input wire logic [7:0]           reg_addr,
    input wire logic                 reg_write,
    input wire logic [31:0]          reg_wdata,
    input wire logic                 ownership_change_request,
    input wire logic                 system_error,
    input wire logic                 shared_done_queue_head_written,
    input wire logic                 schedule_overrun,
    input wire logic                 host_irq,
    input wire logic                 system_mgmt_irq_pin,
    input wire logic                 processing_halt,
    input wire logic                 done_queue_head_hold,
    input wire logic [SOC_WIDTH-1:0] sched_overrun_count
);
    logic [SOC_WIDTH-1:0] count_plus_one;
    assign count_plus_one = sched_overrun_count + 1'b1;

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_status_clear(int b);
        clock_enable && reg_write && reg_addr == 8'h0c && reg_wdata[b];
    endsequence

    a_halt_on_error: assert property (clock_enable && system_error |=> processing_halt)
        else $error("halt did not follow a system error");
    a_halt_stays_set: assert property (
        processing_halt && !(clock_enable && reg_write && reg_addr == 8'h0c && reg_wdata[4])
        |=> processing_halt) else $error("halt dropped without a clear");
    a_hold_on_writeback: assert property (
        clock_enable && shared_done_queue_head_written |=> done_queue_head_hold)
        else $error("hold did not follow a done head copy");
    a_hold_clear_works: assert property (
        s_status_clear(1) ##0 !shared_done_queue_head_written |=> !done_queue_head_hold)
        else $error("hold not cleared by status write");
    a_count_step_up: assert property (
        clock_enable && schedule_overrun |=> sched_overrun_count == $past(count_plus_one))
        else $error("overrun count did not step");
    a_count_holds_still: assert property (
        !(clock_enable && schedule_overrun) |=> $stable(sched_overrun_count))
        else $error("overrun count moved without overrun");
    a_irq_fall_cause: assert property (
        $fell(host_irq) |-> $past(clock_enable && reg_write && reg_addr == 8'h0c))
        else $error("irq dropped without a status write");
    a_smi_rise_cause: assert property ($rose(system_mgmt_irq_pin) |->
        $past(clock_enable && (ownership_change_request || reg_write && reg_addr == 8'h10)))
        else $error("smi rose without cause");
endmodule

bind ohint_core ohint_core_checker #(.SOC_WIDTH(SOC_WIDTH)) u_chk (
    .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .system_error(system_error),
    .ownership_change_request(ownership_change_request), .schedule_overrun(schedule_overrun),
    .shared_done_queue_head_written(shared_done_queue_head_written), .host_irq(host_irq),
    .system_mgmt_irq_pin(system_mgmt_irq_pin), .processing_halt(processing_halt),
    .done_queue_head_hold(done_queue_head_hold), .sched_overrun_count(sched_overrun_count));

`default_nettype wire

// ### ohint_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module ohint_host_model (
    input  wire logic        clock,
    input  wire logic [31:0] reg_rdata,
    output var  logic [7:0]  reg_addr,
    output var  logic        reg_write,
    output var  logic        reg_read,
    output var  logic [31:0] reg_wdata
);
    initial begin
        reg_addr = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 32'h0;
    end

    // Released address and data lines carry the inverse so stale values are never mistaken for live ones.
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= wr;
        reg_read <= !wr;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        #1 q = reg_rdata;
    endtask
endmodule

`default_nettype wire

// ### test_usb_host_ohci_interrupt_status_enable.sv
`timescale 1ns/1ps
`default_nettype none

module test_usb_host_ohci_interrupt_status_enable;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        clock_enable = 1'b1;
    logic [7:0]  ev = 8'h00;
    logic [15:0] frame_number = 16'h0000;
    logic        bus_resume_state = 1'b0;
    logic [7:0]  reg_addr;
    logic        reg_write, reg_read, host_irq, smi, halt, hold;
    logic [31:0] reg_wdata, reg_rdata, q, w;
    logic [1:0]  soc;
    logic        host_irq_b, smi_b;
    logic [31:0] rdata_b;
    int          n_errors = 0;
    int          num_checks = 0;

    always #25 clock = ~clock;

    ohint_core u_dut (
        .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ownership_change_request(ev[7]), .root_hub_change(ev[6]), .frame_number(frame_number),
        .shared_frame_number_written(ev[5] | ev[0]), .system_error(ev[4]),
        .bus_resume_signal(ev[3]), .bus_resume_state(bus_resume_state), .sof_token_issue(ev[2]),
        .shared_done_queue_head_written(ev[1]), .schedule_overrun(ev[0]), .host_irq(host_irq),
        .system_mgmt_irq_pin(smi), .processing_halt(halt), .done_queue_head_hold(hold),
        .sched_overrun_count(soc));

    // A second core built without the management interrupt pin shares every input.
    ohint_core #(.SMI_PIN_PRESENT(1'b0)) u_dut_nosmi (
        .clock(clock), .reset_n(reset_n), .clock_enable(clock_enable), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(rdata_b),
        .ownership_change_request(ev[7]), .root_hub_change(ev[6]), .frame_number(frame_number),
        .shared_frame_number_written(ev[5] | ev[0]), .system_error(ev[4]),
        .bus_resume_signal(ev[3]), .bus_resume_state(bus_resume_state), .sof_token_issue(ev[2]),
        .shared_done_queue_head_written(ev[1]), .schedule_overrun(ev[0]), .host_irq(host_irq_b),
        .system_mgmt_irq_pin(smi_b), .processing_halt(), .done_queue_head_hold(),
        .sched_overrun_count());

    ohint_host_model u_host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic fire(input int k);
        @(posedge clock);
        ev[k] <= 1'b1;
        @(posedge clock);
        ev[k] <= 1'b0;
        #1;
    endtask

    // An overrun is paired with a frame number write, which also raises the overflow flag.
    function automatic logic [31:0] status_of(input int k);
        status_of = (k == 7) ? 32'h4000_0000 : (32'h1 << k);
        if (k == 0) status_of = status_of | 32'h20;
    endfunction

    initial begin
        repeat (1000) @(posedge clock);
        n_errors++;
        conclude();
    end

    initial begin
        void'($urandom(32'hc61af67f));
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        u_host.access(1'b0, 8'h10, 32'h0, q);
        check(q, 32'h0);
        u_host.access(1'b0, 8'h0c, 32'h0, q);
        check(q, 32'h0);
        w = $urandom() & 32'h7fff_ffff;
        u_host.access(1'b1, 8'h10, w, q);
        u_host.access(1'b1, 8'h10, 32'h0, q);
        u_host.access(1'b0, 8'h10, 32'h0, q);
        check(q, w & 32'h4000_007f);
        u_host.access(1'b1, 8'h10, 32'h4000_007f, q);
        fire(2);
        check({31'h0, host_irq}, 32'h0);
        u_host.access(1'b1, 8'h0c, 32'hffff_fffb, q);
        u_host.access(1'b0, 8'h0c, 32'h0, q);
        check(q, 32'h4);
        u_host.access(1'b1, 8'h10, 32'h8000_0000, q);
        check({31'h0, host_irq}, 32'h1);
        u_host.access(1'b0, 8'h10, 32'h0, q);
        check(q, 32'hc000_007f);
        u_host.access(1'b1, 8'h0c, 32'h4, q);
        check({31'h0, host_irq}, 32'h0);
        for (int k = 0; k < 8; k++) begin
            fire(k);
            check({host_irq, smi, halt, hold}, {1'b1, k == 7, k == 4, k == 1});
            check({host_irq_b, smi_b}, {k != 7, 1'b0});
            u_host.access(1'b0, 8'h0c, 32'h0, q);
            check(q, status_of(k));
            check(rdata_b, status_of(k) & 32'hbfff_ffff);
            if (k == 0) begin
                check(soc, 2'h1);
            end
            // The error flag is cleared here by resetting the controller, before the status write.
            if (k == 4) begin
                @(posedge clock);
                reset_n <= 1'b0;
                @(posedge clock);
                reset_n <= 1'b1;
                u_host.access(1'b1, 8'h10, 32'hc000_007f, q);
            end
            // The status has been read back above before every flag is cleared.
            u_host.access(1'b1, 8'h0c, 32'hffff_ffff, q);
            check({smi, hold, halt, host_irq}, 4'h0);
        end
        check(soc, 2'h0);
        @(posedge clock);
        frame_number <= {1'b1, 15'($urandom())};
        bus_resume_state <= 1'b1;
        fire(3);
        // An event offered while the clock enable is low is lost.
        @(posedge clock);
        clock_enable <= 1'b0;
        fire(6);
        @(posedge clock);
        clock_enable <= 1'b1;
        u_host.access(1'b0, 8'h0c, 32'h0, q);
        check(q, 32'h20);
        u_host.access(1'b0, 8'h20, 32'h0, q);
        check(q, 32'h0);
        conclude();
    end
endmodule

`default_nettype wire
